// ==== core/remap_defs.svh ====
// Register offsets, field positions and reset values of the remap control bank
`ifndef REMAP_DEFS_SVH
`define REMAP_DEFS_SVH

`define REMAP_OFF_THIRD          8'h00
`define REMAP_OFF_FIRST          8'h01
`define REMAP_OFF_SECOND         8'h02

`define REMAP_RST_THIRD          8'h00
`define REMAP_RST_FIRST          8'h0C
`define REMAP_RST_SECOND         8'h00

// Second register fields
`define SEC_BREAK_BIT            7
`define SEC_TRIG_B_TWO_BIT       6
`define SEC_SPI_TWO_BIT          5
`define SEC_OSC_B_BIT            4
`define SEC_OSC_A_BIT            3
`define SEC_TRIG_B_ONE_BIT       2
`define SEC_TRIG_A_BIT           1
`define SEC_CONV_TRIG_BIT        0

// Third register fields
`define THI_CH_A2_BIT            7
`define THI_CH_A1_BIT            6
`define THI_CLK_OUT_BIT          5
`define THI_CH_B2_BIT            4
`define THI_CH_B1_BIT            3
`define THI_SP3_CLK_BIT          2
`define THI_SP3_DATA_BIT         1
`define THI_SPI1_TWO_BIT         0

// First register fields
`define FIR_SPI1_ONE_BIT         7
`define FIR_SP1_CLK_BIT          6
`define FIR_SP1_DATA_LSB         4
`define FIR_TIM_C_XFER_LSB       2
`define FIR_CONV_XFER_LSB        0

// Density variant codes
`define DENS_LOW                 2'h0
`define DENS_MEDIUM              2'h1
`define DENS_MEDIUM_PLUS         2'h2
`define DENS_HIGH                2'h3

`endif

// ==== core/remap_pkg.sv ====
// Types of the remap control bank
package remap_pkg;

    // Wishbone request from the master
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } wb_req_t;

    // Selected port line for one signal: port letter index and line number
    typedef struct packed {
        logic [3:0] port;
        logic [2:0] line;
    } pad_sel_t;

    // Port letters
    typedef enum logic [3:0] {
        PORT_A = 4'h0,
        PORT_B = 4'h1,
        PORT_C = 4'h2,
        PORT_D = 4'h3,
        PORT_E = 4'h4,
        PORT_F = 4'h5,
        PORT_G = 4'h6,
        PORT_I = 4'h8,
        PORT_OSC = 4'hF
    } port_t;

endpackage : remap_pkg

// ==== core/remap_control.sv ====
// Remap control bank: three registers that steer alternate functions to port lines
//
// How it works
// - Break select bit routes both timer break inputs: A4/A5 or G0/G1.
// - Timer-b trigger: G3 if select two set, else D1 or A5 by select one.
// - Second serial peripheral pins: G7..G4 when 0, I3..I0 when 1.
// - Timer-b oscillator-trigger bit takes trigger from slow oscillator pad.
// - Timer-a trigger: oscillator pad if bit 3, else B3 or A4 by bit 1.
// - Converter trigger from A6 when 0, D0 when 1.
// - Second register bits 7 and 6 reserved on low and medium density.
// - Timer-a channels 2/1: B2/C6 and B0/C5, 20-pin low density only.
// - Clock output on C4 when 0, E2 when 1.
// - Timer-b channel 2 on D0 or I3, alternate on 80-pin only.
// - Timer-b channel 1 on B1 or I0, alternate on 80-pin only.
// - Third serial port clock on G2 or F2.
// - Third serial port transmit/receive on G1/G0 or F0/F1.
// - First serial peripheral pins B7..B4, A2/A3/C6/C5 by select one, or F0..F3 by select two.
// - Third register only on 20-pin low, medium+, high; bits 7/6 reserved on medium+/high.
// - Second and third registers reset to zero, default lines.
// - First register resets with timer-c transfer field 11, others zero.
// - Transfer-channel fields pick engine channel 0..3 by value.
// - First serial port data: C3/C2, A2/A3, C5/C6; 11 reserved.
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ns
`include "remap_defs.svh"

module remap_control
    import remap_pkg::*;
#(
    parameter logic [1:0] DENSITY  = `DENS_HIGH,
    parameter int         PIN_COUNT = 80
) (
    input  wire logic      clk_i,
    input  wire logic      rst_i,
    // Wishbone classic slave
    input  wire logic      wb_cyc_i,
    input  wire logic      wb_stb_i,
    input  wire logic      wb_we_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]    wb_dat_o,
    output logic           wb_ack_o,
    output logic           wb_err_o,
    // Routing selections toward the pad mux, then two transfer-engine channels
    output pad_sel_t       timer_a_break_input_o,
    output pad_sel_t       timer_b_break_input_o,
    output pad_sel_t       timer_a_trigger_input_o,
    output pad_sel_t       timer_b_trigger_input_o,
    output pad_sel_t       converter_trigger_input_o,
    output pad_sel_t       spi_two_miso_o,
    output pad_sel_t       spi_two_mosi_o,
    output pad_sel_t       spi_two_sck_o,
    output pad_sel_t       spi_two_nss_o,
    output pad_sel_t       timer_a_channel_two_o,
    output pad_sel_t       timer_a_channel_one_o,
    output pad_sel_t       configurable_clock_output_o,
    output pad_sel_t       timer_b_channel_two_o,
    output pad_sel_t       timer_b_channel_one_o,
    output pad_sel_t       serial_three_clock_o,
    output pad_sel_t       serial_three_tx_o,
    output pad_sel_t       serial_three_rx_o,
    output pad_sel_t       spi_one_miso_o,
    output pad_sel_t       spi_one_mosi_o,
    output pad_sel_t       spi_one_sck_o,
    output pad_sel_t       spi_one_nss_o,
    output pad_sel_t       serial_one_clock_o,
    output pad_sel_t       serial_one_tx_o,
    output pad_sel_t       serial_one_rx_o,
    output logic [1:0]     timer_c_transfer_channel_o,
    output logic [1:0]     converter_transfer_channel_o
);

    // Only the package sizes the variant gating knows about are served
    if (PIN_COUNT != 20 && PIN_COUNT != 28 && PIN_COUNT != 32 && PIN_COUNT != 48 &&
        PIN_COUNT != 64 && PIN_COUNT != 80) begin : g_bad_pin_count
        $error("Unsupported pin count");
    end

    // ********************************************************************
    // Variant gating
    // ********************************************************************
    // Writable masks are fixed at elaboration so reserved bits can never hold a one
    localparam logic third_present = (DENSITY == `DENS_LOW && PIN_COUNT == 20) ||
                                     DENSITY == `DENS_MEDIUM_PLUS || DENSITY == `DENS_HIGH;
    localparam logic ch_a_present  = (DENSITY == `DENS_LOW && PIN_COUNT == 20);
    localparam logic big_pkg       = (PIN_COUNT == 80);
    localparam logic sec_hi_ok     = DENSITY == `DENS_MEDIUM_PLUS || DENSITY == `DENS_HIGH;

    localparam logic [7:0] mask_second = sec_hi_ok ? 8'hFF : 8'h3F;
    localparam logic [7:0] mask_third  = !third_present ? 8'h00 :
                                         (ch_a_present ? 8'hFF : 8'h3F);

    // ********************************************************************
    // Register bus
    // ********************************************************************
    wb_req_t req;
    assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i, adr: wb_adr_i, dat: wb_dat_i};

    logic [7:0] first_q,  first_d;
    logic [7:0] second_q, second_d;
    logic [7:0] third_q,  third_d;
    logic       ack_q;
    logic       err_q;
    logic [31:0] rdat_q;

    // Register index is the word address; printed offsets are not multiples of four
    wire         access   = req.cyc && req.stb && !ack_q && !err_q;
    wire  [5:0]  word_idx = req.adr[7:2];
    wire         hit_first  = (word_idx == `REMAP_OFF_FIRST);
    wire         hit_second = (word_idx == `REMAP_OFF_SECOND);
    wire         hit_third  = (word_idx == `REMAP_OFF_THIRD) && third_present;
    wire         mapped   = hit_first || hit_second || hit_third;
    wire         wr_lane  = access && req.we && req.sel[0];
    wire  [7:0]  wbyte    = req.dat[7:0];

    // Value 11 of the first serial port data field is refused and the old value kept
    wire  [1:0]  sp1_new  = wbyte[`FIR_SP1_DATA_LSB +: 2];
    wire  [7:0]  first_w  = (sp1_new == 2'h3) ?
                            {wbyte[7:6], first_q[`FIR_SP1_DATA_LSB +: 2], wbyte[3:0]} : wbyte;

    assign first_d  = (wr_lane && hit_first)  ? first_w               : first_q;
    assign second_d = (wr_lane && hit_second) ? (wbyte & mask_second) : second_q;
    assign third_d  = (wr_lane && hit_third)  ? (wbyte & mask_third)  : third_q;

    wire  [7:0]  rbyte = hit_first ? first_q : hit_second ? second_q : hit_third ? third_q : 8'h00;
    wire  [31:0] rdat_d = {24'h0000_00, rbyte};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            first_q  <= `REMAP_RST_FIRST;
            second_q <= `REMAP_RST_SECOND;
            third_q  <= `REMAP_RST_THIRD;
            ack_q    <= 1'b0;
            err_q    <= 1'b0;
            rdat_q   <= 32'h0000_0000;
        end else begin
            first_q  <= first_d;
            second_q <= second_d;
            third_q  <= third_d;
            ack_q    <= access && mapped;
            err_q    <= access && !mapped;
            rdat_q   <= (access && !req.we) ? rdat_d : 32'h0000_0000;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_err_o = err_q;
    assign wb_dat_o = rdat_q;

    // ********************************************************************
    // Routing decode
    // ********************************************************************
    // Oscillator pin timing is the software's job: prescaler ratio >= 4 first
    function automatic pad_sel_t pad(input port_t p, input logic [2:0] l);
        pad = '{port: p, line: l};
    endfunction : pad

    wire brk   = second_q[`SEC_BREAK_BIT];
    wire trb2  = second_q[`SEC_TRIG_B_TWO_BIT];
    wire spi2  = second_q[`SEC_SPI_TWO_BIT];
    wire oscb  = second_q[`SEC_OSC_B_BIT];
    wire osca  = second_q[`SEC_OSC_A_BIT];
    wire trb1  = second_q[`SEC_TRIG_B_ONE_BIT];
    wire tra   = second_q[`SEC_TRIG_A_BIT];
    wire cnvt  = second_q[`SEC_CONV_TRIG_BIT];
    wire cha2  = third_q[`THI_CH_A2_BIT];
    wire cha1  = third_q[`THI_CH_A1_BIT];
    wire cko   = third_q[`THI_CLK_OUT_BIT];
    wire chb2  = third_q[`THI_CH_B2_BIT] && big_pkg;
    wire chb1  = third_q[`THI_CH_B1_BIT] && big_pkg;
    wire sp3c  = third_q[`THI_SP3_CLK_BIT];
    wire sp3d  = third_q[`THI_SP3_DATA_BIT];
    wire spi1b = third_q[`THI_SPI1_TWO_BIT];
    wire spi1a = first_q[`FIR_SPI1_ONE_BIT];
    wire sp1c  = first_q[`FIR_SP1_CLK_BIT];
    wire [1:0] sp1d = first_q[`FIR_SP1_DATA_LSB +: 2];

    pad_sel_t trig_b_pin;
    assign trig_b_pin = trb2 ? pad(PORT_G, 3'd3) : (trb1 ? pad(PORT_A, 3'd5) : pad(PORT_D, 3'd1));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_a_break_input_o        <= '0;
            timer_b_break_input_o        <= '0;
            timer_a_trigger_input_o      <= '0;
            timer_b_trigger_input_o      <= '0;
            converter_trigger_input_o    <= '0;
            spi_two_miso_o               <= '0;
            spi_two_mosi_o               <= '0;
            spi_two_sck_o                <= '0;
            spi_two_nss_o                <= '0;
            timer_a_channel_two_o        <= '0;
            timer_a_channel_one_o        <= '0;
            configurable_clock_output_o  <= '0;
            timer_b_channel_two_o        <= '0;
            timer_b_channel_one_o        <= '0;
            serial_three_clock_o         <= '0;
            serial_three_tx_o            <= '0;
            serial_three_rx_o            <= '0;
            spi_one_miso_o               <= '0;
            spi_one_mosi_o               <= '0;
            spi_one_sck_o                <= '0;
            spi_one_nss_o                <= '0;
            serial_one_clock_o           <= '0;
            serial_one_tx_o              <= '0;
            serial_one_rx_o              <= '0;
            timer_c_transfer_channel_o   <= 2'h3;
            converter_transfer_channel_o <= 2'h0;
        end else begin
            timer_a_break_input_o     <= brk ? pad(PORT_G, 3'd0) : pad(PORT_A, 3'd4);
            timer_b_break_input_o     <= brk ? pad(PORT_G, 3'd1) : pad(PORT_A, 3'd5);
            timer_b_trigger_input_o   <= oscb ? pad(PORT_OSC, 3'd0) : trig_b_pin;
            timer_a_trigger_input_o   <= osca ? pad(PORT_OSC, 3'd0) :
                                         (tra ? pad(PORT_A, 3'd4) : pad(PORT_B, 3'd3));
            converter_trigger_input_o <= cnvt ? pad(PORT_D, 3'd0) : pad(PORT_A, 3'd6);
            spi_two_miso_o <= spi2 ? pad(PORT_I, 3'd3) : pad(PORT_G, 3'd7);
            spi_two_mosi_o <= spi2 ? pad(PORT_I, 3'd2) : pad(PORT_G, 3'd6);
            spi_two_sck_o  <= spi2 ? pad(PORT_I, 3'd1) : pad(PORT_G, 3'd5);
            spi_two_nss_o  <= spi2 ? pad(PORT_I, 3'd0) : pad(PORT_G, 3'd4);
            timer_a_channel_two_o <= cha2 ? pad(PORT_C, 3'd6) : pad(PORT_B, 3'd2);
            timer_a_channel_one_o <= cha1 ? pad(PORT_C, 3'd5) : pad(PORT_B, 3'd0);
            configurable_clock_output_o <= cko ? pad(PORT_E, 3'd2) : pad(PORT_C, 3'd4);
            timer_b_channel_two_o <= chb2 ? pad(PORT_I, 3'd3) : pad(PORT_D, 3'd0);
            timer_b_channel_one_o <= chb1 ? pad(PORT_I, 3'd0) : pad(PORT_B, 3'd1);
            serial_three_clock_o  <= sp3c ? pad(PORT_F, 3'd2) : pad(PORT_G, 3'd2);
            serial_three_tx_o     <= sp3d ? pad(PORT_F, 3'd0) : pad(PORT_G, 3'd1);
            serial_three_rx_o     <= sp3d ? pad(PORT_F, 3'd1) : pad(PORT_G, 3'd0);
            // Select two wins over select one when both are set
            spi_one_miso_o <= spi1b ? pad(PORT_F, 3'd0) : spi1a ? pad(PORT_A, 3'd2) : pad(PORT_B, 3'd7);
            spi_one_mosi_o <= spi1b ? pad(PORT_F, 3'd1) : spi1a ? pad(PORT_A, 3'd3) : pad(PORT_B, 3'd6);
            spi_one_sck_o  <= spi1b ? pad(PORT_F, 3'd2) : spi1a ? pad(PORT_C, 3'd6) : pad(PORT_B, 3'd5);
            spi_one_nss_o  <= spi1b ? pad(PORT_F, 3'd3) : spi1a ? pad(PORT_C, 3'd5) : pad(PORT_B, 3'd4);
            serial_one_clock_o <= sp1c ? pad(PORT_A, 3'd0) : pad(PORT_C, 3'd4);
            serial_one_tx_o <= (sp1d == 2'h1) ? pad(PORT_A, 3'd2) :
                               (sp1d == 2'h2) ? pad(PORT_C, 3'd5) : pad(PORT_C, 3'd3);
            serial_one_rx_o <= (sp1d == 2'h1) ? pad(PORT_A, 3'd3) :
                               (sp1d == 2'h2) ? pad(PORT_C, 3'd6) : pad(PORT_C, 3'd2);
            timer_c_transfer_channel_o   <= first_q[`FIR_TIM_C_XFER_LSB +: 2];
            converter_transfer_channel_o <= first_q[`FIR_CONV_XFER_LSB +: 2];
        end
    end

endmodule : remap_control

// ==== tb/remap_control_monitor.sv ====
// Port checks of the remap control bank
`timescale 1ns/1ns

module remap_control_monitor
    import remap_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o,
    input  wire logic        wb_err_o,
    input  wire pad_sel_t    timer_a_break_input_o,
    input  wire pad_sel_t    converter_trigger_input_o,
    input  wire logic [1:0]  timer_c_transfer_channel_o,
    input  wire logic [1:0]  converter_transfer_channel_o
);
    // A request is taken only while no answer is pending
    logic take_w;
    logic wr_w;
    assign take_w = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign wr_w   = take_w && wb_we_i && wb_sel_i[0];

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_ACK_NEXT: assert property (take_w && wb_adr_i < 8'h0C |=> wb_ack_o && !wb_err_o)
        else $error("mapped request not answered");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    AST_ERR_UNMAPPED: assert property (take_w && wb_adr_i >= 8'h0C |=> wb_err_o && !wb_ack_o)
        else $error("unmapped request not refused");
    AST_THIRD_RESERVED: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) < 8'h04
        |-> wb_dat_o[31:6] == 26'h0) else $error("reserved bits read nonzero");
    AST_BREAK_ROUTE: assert property (wr_w && wb_adr_i == 8'h08 |-> ##2
        timer_a_break_input_o == ($past(wb_dat_i[7], 2) ? {PORT_G, 3'h0} : {PORT_A, 3'h4}))
        else $error("break input route wrong");
    AST_CONV_ROUTE: assert property (wr_w && wb_adr_i == 8'h08 |-> ##2
        converter_trigger_input_o == ($past(wb_dat_i[0], 2) ? {PORT_D, 3'h0} : {PORT_A, 3'h6}))
        else $error("converter trigger route wrong");
    AST_XFER_ROUTE: assert property (wr_w && wb_adr_i == 8'h04 |-> ##2
        {timer_c_transfer_channel_o, converter_transfer_channel_o} == $past(wb_dat_i[3:0], 2))
        else $error("transfer channel wrong");
    AST_RESET_XFER: assert property ($past(rst_i) |-> timer_c_transfer_channel_o == 2'h3)
        else $error("transfer channel reset wrong");
endmodule : remap_control_monitor

// ==== tb/trigger_receiver_model.sv ====
// Timer trigger receiver that flags an oscillator trigger chosen too early
`timescale 1ns/1ns

module trigger_receiver_model
    import remap_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire pad_sel_t   trigger_sel_i,
    input  wire logic [3:0] prescale_ratio_i,
    input  wire logic       osc_running_i,
    output logic            misuse_o
);
    // Sticky, so a short misuse between checks is not lost
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            misuse_o <= 1'b0;
        end else if (trigger_sel_i.port == PORT_OSC && (prescale_ratio_i < 4'h4 || !osc_running_i)) begin
            misuse_o <= 1'b1;
        end
    end
endmodule : trigger_receiver_model

// ==== tb/remap_control_bench.sv ====
// Self-checking bench of the remap control bank
`timescale 1ns/1ns

`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin err_count++; $display("mismatch %s expected %0h seen %0h", nm, ex, gt); end end

module remap_control_bench
    import remap_pkg::*;
();
    typedef struct packed {
        logic [7:0] adr;
        logic [7:0] wd;
        logic [7:0] rd;
        logic [3:0] idx;
        pad_sel_t   exp;
    } row_t;
    // ****************************************
    // Write, read back, then the routed line
    // ****************************************
    localparam row_t ROWS [0:18] = '{
        '{8'h08, 8'h80, 8'h80, 4'h0, {PORT_G, 3'h0}}, '{8'h08, 8'h40, 8'h40, 4'h1, {PORT_G, 3'h3}},
        '{8'h08, 8'h04, 8'h04, 4'h1, {PORT_A, 3'h5}}, '{8'h08, 8'h14, 8'h14, 4'h1, {PORT_OSC, 3'h0}},
        '{8'h08, 8'h0A, 8'h0A, 4'h2, {PORT_OSC, 3'h0}}, '{8'h08, 8'h02, 8'h02, 4'h2, {PORT_A, 3'h4}},
        '{8'h08, 8'h00, 8'h00, 4'h2, {PORT_B, 3'h3}}, '{8'h08, 8'h20, 8'h20, 4'h3, {PORT_I, 3'h3}},
        '{8'h08, 8'h01, 8'h01, 4'h4, {PORT_D, 3'h0}}, '{8'h00, 8'h20, 8'h20, 4'h5, {PORT_E, 3'h2}},
        '{8'h00, 8'h10, 8'h10, 4'h6, {PORT_I, 3'h3}}, '{8'h00, 8'h08, 8'h08, 4'h7, {PORT_I, 3'h0}},
        '{8'h00, 8'h04, 8'h04, 4'h8, {PORT_F, 3'h2}}, '{8'h00, 8'h02, 8'h02, 4'h9, {PORT_F, 3'h0}},
        '{8'h00, 8'hC1, 8'h01, 4'hA, {PORT_F, 3'h0}}, '{8'h04, 8'h10, 8'h10, 4'hB, {PORT_A, 3'h2}},
        '{8'h04, 8'h30, 8'h10, 4'hB, {PORT_A, 3'h2}}, '{8'h04, 8'h0E, 8'h0E, 4'hC, 7'h02},
        '{8'h04, 8'h24, 8'h24, 4'hD, 7'h01}
    };
    logic          clk = 1'b0;
    logic          rst = 1'b1;
    wb_req_t       req = '0;
    logic [31:0]   rdat;
    logic          ack;
    logic          err;
    logic [1:0]    xfer_c;
    logic [1:0]    xfer_t;
    wire pad_sel_t pr [0:13];
    logic          misuse;
    logic [31:0]   got;
    logic          gerr;
    pad_sel_t      seen;
    int            err_count = 0;
    int            cmp_count = 0;
    int            cycles = 0;

    assign pr[12] = {5'h00, xfer_c};
    assign pr[13] = {5'h00, xfer_t};
    always #50 clk = ~clk;

    remap_control dut (
        .clk_i(clk), .rst_i(rst), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb), .wb_we_i(req.we), .wb_sel_i(req.sel),
        .wb_adr_i(req.adr), .wb_dat_i(req.dat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
        .timer_a_break_input_o(pr[0]), .timer_b_break_input_o(), .timer_a_trigger_input_o(pr[2]),
        .timer_b_trigger_input_o(pr[1]), .converter_trigger_input_o(pr[4]), .spi_two_miso_o(pr[3]),
        .spi_two_mosi_o(), .spi_two_sck_o(), .spi_two_nss_o(), .timer_a_channel_two_o(), .timer_a_channel_one_o(),
        .configurable_clock_output_o(pr[5]), .timer_b_channel_two_o(pr[6]), .timer_b_channel_one_o(pr[7]),
        .serial_three_clock_o(pr[8]), .serial_three_tx_o(pr[9]), .serial_three_rx_o(), .spi_one_miso_o(pr[10]),
        .spi_one_mosi_o(), .spi_one_sck_o(), .spi_one_nss_o(), .serial_one_clock_o(), .serial_one_tx_o(pr[11]),
        .serial_one_rx_o(), .timer_c_transfer_channel_o(xfer_t), .converter_transfer_channel_o(xfer_c)
    );
    // Prescaler set and oscillator running before any oscillator trigger is chosen
    trigger_receiver_model far (.clk_i(clk), .rst_i(rst), .trigger_sel_i(pr[1]), .prescale_ratio_i(4'h4),
                                .osc_running_i(1'b1), .misuse_o(misuse));

    task automatic wb_xfer(input logic [7:0] a, input logic w, input logic [7:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{1'b1, 1'b1, w, s, a, {24'h00_0000, d}};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 16);
        got = rdat;
        gerr = err;
        // A slave that never answers is a failure, not a silent pass
        if (ack !== 1'b1 && err !== 1'b1) begin
            err_count++;
            $display("mismatch answer expected 1 seen 0");
        end
        req <= '0;
    endtask : wb_xfer

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict

    // Whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            err_count++;
            give_verdict();
        end
    end

    initial begin
        int i;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 19; i++) begin
            wb_xfer(ROWS[i].adr, 1'b1, ROWS[i].wd, 4'h1);
            wb_xfer(ROWS[i].adr, 1'b0, 8'h00, 4'h1);
            `CHK("readback", {24'h00_0000, ROWS[i].rd}, got)
            seen = pr[ROWS[i].idx];
            if (ROWS[i].exp.port == PORT_OSC) begin
                seen.line = ROWS[i].exp.line;
            end
            `CHK("routing", ROWS[i].exp, seen)
        end
        $display("test table done");
        wb_xfer(8'h08, 1'b1, 8'hFF, 4'h0);
        wb_xfer(8'h08, 1'b0, 8'h00, 4'h1);
        `CHK("byte enable", 32'h0000_0001, got)
        wb_xfer(8'h0C, 1'b1, 8'h55, 4'h1);
        `CHK("unmapped", 1'b1, gerr)
        $display("test refusals done");
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 3; i++) begin
            wb_xfer(8'(i * 4), 1'b0, 8'h00, 4'h1);
            `CHK("reset value", (i == 1) ? 32'h0000_000C : 32'h0000_0000, got)
        end
        `CHK("reset converter route", {PORT_A, 3'h6}, pr[4])
        `CHK("reset transfer channel", 7'h03, pr[13])
        `CHK("trigger misuse", 1'b0, misuse)
        $display("test reset done");
        give_verdict();
    end
endmodule : remap_control_bench

bind remap_control remap_control_monitor mon (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .timer_a_break_input_o(timer_a_break_input_o), .converter_trigger_input_o(converter_trigger_input_o),
    .timer_c_transfer_channel_o(timer_c_transfer_channel_o),
    .converter_transfer_channel_o(converter_transfer_channel_o)
);
